// [rtl/sibt_pin_sync.sv]
// Three-stage synchroniser for one bus pin.
// Assumes the pin is asynchronous; output moves when stages two and three agree.
`timescale 1ns/1ps
module sibt_pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// Clock, enable and reset
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_reset_n,
	// Pin and qualified level
	input wire logic i_pin,
	output logic o_level
);

	logic [2:0] stage_q;
	logic level_q;

	// Shift chain; the first stage feeds only the second
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage_q <= {3{RESET_LEVEL}};
			level_q <= RESET_LEVEL;
		end else if (i_clk_en) begin
			stage_q <= {stage_q[1:0], i_pin};
			if (stage_q[1] == stage_q[2]) begin
				level_q <= stage_q[2];
			end
		end
	end

	assign o_level = level_q;

endmodule

// [rtl/sibt_pkg.sv]
// Constants, types and carriers for the indexed block serial target.
// Assumes one system clock; the bus pins are asynchronous to it.
package sibt_pkg;

	// ------------------------------------------------------------
	// Addresses, field positions and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SIBT_WR_ADDR = 8'hd2;
	localparam logic [7:0] SIBT_RD_ADDR = SIBT_WR_ADDR | 8'h01;
	localparam logic [7:0] SIBT_COUNT_INDEX = 8'h08;
	localparam logic [7:0] SIBT_DEF_READ_COUNT = 8'h08;
	localparam logic [3:0] SIBT_BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] SIBT_BYTE_RESET = 8'h00;
	localparam int SIBT_MSB = 7;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SIBT_S_IDLE,
		SIBT_S_RX,
		SIBT_S_RXACK,
		SIBT_S_TX,
		SIBT_S_TXACK
	} sibt_state_t;

	typedef enum logic [2:0] {
		SIBT_G_ADDR,
		SIBT_G_INDEX,
		SIBT_G_COUNT,
		SIBT_G_DATA,
		SIBT_G_READ
	} sibt_stage_t;

	// Write strobe toward the register file
	typedef struct packed {
		logic en;
		logic [7:0] index;
		logic [7:0] data;
	} sibt_wr_t;

	// Whole state of the target engine
	typedef struct packed {
		sibt_state_t st;
		sibt_stage_t stage;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [7:0] idx;
		logic [7:0] rem;
		logic [7:0] cnt8;
		logic cnt_set;
		logic acked;
		logic scl_p;
		logic sda_p;
		logic sda_o;
		logic sda_oe_n;
		logic busy;
		logic [7:0] rd_idx;
		sibt_wr_t wr;
	} sibt_core_t;

endpackage

// [rtl/sibt_target.sv]
// Serial target engine for indexed block reads and writes.
// Assumes register storage outside, read combinationally from o_rd_index.
`timescale 1ns/1ps
module sibt_target
	import sibt_pkg::*;
#(
	parameter logic [7:0] READ_COUNT = SIBT_DEF_READ_COUNT
) (
	// Clock, enable and reset
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_reset_n,
	// Bus pins; data line is open drain
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Register file side
	output sibt_wr_t o_wr,
	output logic [7:0] o_rd_index,
	input wire logic [7:0] i_rd_data,
	output logic o_busy
);

	// ------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] rst_q;
	logic rst_n;
	logic scl;
	logic sda;

	// Reset asserts at once and releases after two edges
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_q <= 2'b00;
		end else if (i_clk_en) begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	sibt_pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
		.i_clock(i_clock),
		.i_clk_en(i_clk_en),
		.i_reset_n(rst_n),
		.i_pin(i_scl),
		.o_level(scl)
	);

	sibt_pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
		.i_clock(i_clock),
		.i_clk_en(i_clk_en),
		.i_reset_n(rst_n),
		.i_pin(i_sda),
		.o_level(sda)
	);

	// ------------------------------------------------------------
	// Bus events
	// ------------------------------------------------------------
	sibt_core_t q;
	sibt_core_t d;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic [7:0] count_byte;

	// Edges of the clock line, start and stop while it is high
	assign scl_rise = scl & ~q.scl_p;
	assign scl_fall = ~scl & q.scl_p;
	assign start_ev = scl & q.scl_p & q.sda_p & ~sda;
	assign stop_ev = scl & q.scl_p & ~q.sda_p & sda;
	// Count byte sent first on a read
	assign count_byte = q.cnt_set ? q.cnt8 : READ_COUNT;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.scl_p = scl;
		d.sda_p = sda;
		d.sda_o = 1'b0;
		d.wr.en = 1'b0;
		if (start_ev) begin
			// Start or repeated start opens a fresh address byte
			d.st = SIBT_S_RX;
			d.stage = SIBT_G_ADDR;
			d.bitc = 4'h0;
			d.sda_oe_n = 1'b1;
		end else if (stop_ev) begin
			d.st = SIBT_S_IDLE;
			d.sda_oe_n = 1'b1;
		end else begin
			case (q.st)
				SIBT_S_RX: begin
					if (scl_rise) begin
						d.sh = {q.sh[6:0], sda};
						d.bitc = q.bitc + 4'h1;
					end else if (scl_fall && q.bitc == SIBT_BITS_PER_BYTE) begin
						// Byte complete: acknowledge unless refused below
						d.sda_oe_n = 1'b0;
						d.st = SIBT_S_RXACK;
						case (q.stage)
							SIBT_G_ADDR: begin
								if (q.sh == SIBT_WR_ADDR) begin
									d.stage = SIBT_G_INDEX;
								end else if (q.sh == SIBT_RD_ADDR) begin
									d.stage = SIBT_G_READ;
									d.rd_idx = q.cnt_set ? SIBT_BYTE_RESET : q.idx;
								end else begin
									d.sda_oe_n = 1'b1;
									d.st = SIBT_S_IDLE;
								end
							end
							SIBT_G_INDEX: begin
								d.idx = q.sh;
								d.stage = SIBT_G_COUNT;
							end
							SIBT_G_COUNT: begin
								d.rem = q.sh;
								d.stage = SIBT_G_DATA;
							end
							SIBT_G_DATA: begin
								if (q.rem != SIBT_BYTE_RESET) begin
									// Store at the running index, then advance
									d.wr.en = 1'b1;
									d.wr.index = q.idx;
									d.wr.data = q.sh;
									d.idx = q.idx + 8'h01;
									d.rem = q.rem - 8'h01;
									if (q.idx == SIBT_COUNT_INDEX) begin
										d.cnt8 = q.sh;
										d.cnt_set = 1'b1;
									end
								end else begin
									// Bytes beyond the count are refused
									d.sda_oe_n = 1'b1;
									d.st = SIBT_S_IDLE;
								end
							end
							default: begin
								d.sda_oe_n = 1'b1;
								d.st = SIBT_S_IDLE;
							end
						endcase
					end
				end
				SIBT_S_RXACK: begin
					if (scl_fall) begin
						if (q.stage == SIBT_G_READ) begin
							// Count byte leads the read data
							d.sda_oe_n = count_byte[SIBT_MSB];
							d.sh = {count_byte[6:0], 1'b0};
							d.bitc = 4'h1;
							d.st = SIBT_S_TX;
						end else begin
							d.sda_oe_n = 1'b1;
							d.bitc = 4'h0;
							d.st = SIBT_S_RX;
						end
					end
				end
				SIBT_S_TX: begin
					if (scl_fall) begin
						if (q.bitc == SIBT_BITS_PER_BYTE) begin
							// Free the line for the host's answer
							d.sda_oe_n = 1'b1;
							d.st = SIBT_S_TXACK;
						end else begin
							d.sda_oe_n = q.sh[SIBT_MSB];
							d.sh = {q.sh[6:0], 1'b0};
							d.bitc = q.bitc + 4'h1;
						end
					end
				end
				SIBT_S_TXACK: begin
					if (scl_rise) begin
						d.acked = ~sda;
					end else if (scl_fall) begin
						if (q.acked) begin
							// Next register byte, then advance the index
							d.sda_oe_n = i_rd_data[SIBT_MSB];
							d.sh = {i_rd_data[6:0], 1'b0};
							d.bitc = 4'h1;
							d.rd_idx = q.rd_idx + 8'h01;
							d.st = SIBT_S_TX;
						end else begin
							d.sda_oe_n = 1'b1;
							d.st = SIBT_S_IDLE;
						end
					end
				end
				default: begin
					d.sda_oe_n = 1'b1;
					d.st = SIBT_S_IDLE;
				end
			endcase
		end
		d.busy = (d.st != SIBT_S_IDLE);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{st: SIBT_S_IDLE, stage: SIBT_G_ADDR, bitc: 4'h0,
				sh: SIBT_BYTE_RESET, idx: SIBT_BYTE_RESET, rem: SIBT_BYTE_RESET,
				cnt8: SIBT_BYTE_RESET, cnt_set: 1'b0, acked: 1'b0,
				scl_p: 1'b1, sda_p: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1,
				busy: 1'b0, rd_idx: SIBT_BYTE_RESET,
				wr: '{en: 1'b0, index: SIBT_BYTE_RESET, data: SIBT_BYTE_RESET}};
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign o_sda = q.sda_o;
	assign o_sda_oe_n = q.sda_oe_n;
	assign o_wr = q.wr;
	assign o_rd_index = q.rd_idx;
	assign o_busy = q.busy;

endmodule

// [sim/sibt_host_model.sv]
// Host controller model for the serial bus.
// Assumes an open drain data line with pull-up.
`timescale 1ns/1ps
module sibt_host_model (
	// Clock and wired line
	input wire logic i_clock,
	input wire logic i_line,
	// Bus levels, 1 releases
	output logic o_scl,
	output logic o_sda
);
	logic ph;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		ph = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	// Start or repeated start
	task automatic start;
		w(3);
		o_sda = 1'b1;
		w(4);
		o_scl = 1'b1;
		w(5);
		o_sda = 1'b0;
		w(5);
		o_scl = 1'b0;
	endtask
	// Stop closes each transfer
	task automatic stop;
		w(3);
		o_sda = 1'b0;
		w(4);
		o_scl = 1'b1;
		w(5);
		o_sda = 1'b1;
		w(5);
	endtask
	// One bit; periods alternate so they average 125 ns
	task automatic bit_x(input logic b, output logic r);
		w(3);
		o_sda = b;
		w(4);
		o_scl = 1'b1;
		w(2);
		r = i_line;
		w(3 + ph);
		o_scl = 1'b0;
		ph = ~ph;
	endtask
	// Byte then ninth bit; a is the host's answer to a read byte
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
			output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a, k);
	endtask
endmodule

// [sim/sibt_target_sva.sv]
// Port assertions for the serial target.
// Assumes binding to sibt_target; pins reach the core a few cycles late.
`timescale 1ns/1ps
module sibt_target_sva
	import sibt_pkg::*;
#(
	parameter logic [7:0] READ_COUNT = SIBT_DEF_READ_COUNT
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_clk_en,
	input wire logic i_reset_n,
	// Bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	// Register side
	input wire sibt_wr_t o_wr,
	input wire logic [7:0] o_rd_index,
	input wire logic [7:0] i_rd_data,
	input wire logic o_busy
);
	// ---
	// Helpers
	// ---
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	logic [7:0] last_q;
	logic seen_q;
	// Last stored index within the current transfer
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_q <= 1'b0;
			last_q <= 8'h00;
		end else if (!o_busy) begin
			seen_q <= 1'b0;
		end else if (o_wr.en) begin
			seen_q <= 1'b1;
			last_q <= o_wr.index;
		end
	end
	// ---
	// Properties
	// ---
	sequence s_start; i_scl && $fell(i_sda); endsequence
	sequence s_stop; i_scl && $rose(i_sda); endsequence
	property p_wake; s_start |-> ##[1:8] o_busy; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_stop; s_stop |-> ##[1:8] !o_busy; endproperty
	a_stop: assert property (p_stop) else $error("no idle");
	property p_one; o_wr.en |=> !o_wr.en; endproperty
	a_one: assert property (p_one) else $error("long strobe");
	property p_wack; o_wr.en |-> !o_sda_oe_n; endproperty
	a_wack: assert property (p_wack) else $error("store unacked");
	property p_inc; o_wr.en && seen_q |-> o_wr.index == last_q + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("index skip");
	property p_low; !o_sda_oe_n |-> !o_sda && o_busy; endproperty
	a_low: assert property (p_low) else $error("bad drive");
	property p_hold; $fell(o_sda_oe_n) |=> !o_sda_oe_n [*4]; endproperty
	a_hold: assert property (p_hold) else $error("short bit");
	property p_pin; $changed(o_sda_oe_n) |-> !i_scl; endproperty
	a_pin: assert property (p_pin) else $error("change at high");
endmodule
bind sibt_target sibt_target_sva #(.READ_COUNT(READ_COUNT)) sibt_target_sva_inst (
	.i_clock(i_clock), .i_clk_en(i_clk_en), .i_reset_n(i_reset_n), .i_scl(i_scl),
	.i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_wr(o_wr),
	.o_rd_index(o_rd_index), .i_rd_data(i_rd_data), .o_busy(o_busy));

// [sim/smbus_indexed_block_target_tb.sv]
// Self-checking bench for the serial target.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module smbus_indexed_block_target_tb;
	import sibt_pkg::*;
	// ---
	// Wiring
	// ---
	localparam logic [7:0] RC = 8'h06;
	logic [31:0] rows [3] = '{32'h0301_aa00, 32'hff02_1234, 32'h1002_00ff};
	logic i_clock, i_reset_n, scl, hsda, line, q_a, o_sda, o_sda_oe_n, o_busy, clk_en;
	logic [7:0] rd_idx, q;
	logic [7:0] mem [256];
	logic [7:0] exp_m [256];
	sibt_wr_t o_wr;
	int errors, total_checks;
	assign line = hsda & (o_sda_oe_n | o_sda);
	sibt_target #(.READ_COUNT(RC)) sibt_target_inst (.i_clock(i_clock), .i_clk_en(clk_en),
		.i_reset_n(i_reset_n), .i_scl(scl), .i_sda(line), .o_sda(o_sda),
		.o_sda_oe_n(o_sda_oe_n), .o_wr(o_wr), .o_rd_index(rd_idx),
		.i_rd_data(mem[rd_idx]), .o_busy(o_busy));
	sibt_host_model sibt_host_model_inst (.i_clock(i_clock), .i_line(line), .o_scl(scl),
		.o_sda(hsda));
	// ---
	// Tasks
	// ---
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wx(input logic [7:0] d, input logic e);
		sibt_host_model_inst.xfer(d, 1'b1, q, q_a);
		chk(8'(q_a), 8'(e));
	endtask
	// Block write, x adds one byte past the count
	task automatic bw(input logic [7:0] n, input logic [7:0] c, input logic [15:0] d,
			input logic x);
		sibt_host_model_inst.start();
		wx(SIBT_WR_ADDR, 1'b0);
		wx(n, 1'b0);
		wx(c, 1'b0);
		for (int k = 0; k < c; k++) begin
			wx(d[15 - 8 * k -: 8], 1'b0);
			exp_m[8'(n + k)] = d[15 - 8 * k -: 8];
		end
		if (x) wx(8'h22, 1'b1);
		sibt_host_model_inst.stop();
		chk(8'(o_busy), 8'h00);
		chk(mem[8'(n + c)], exp_m[8'(n + c)]);
		chk(mem[8'(n + c - 1)], exp_m[8'(n + c - 1)]);
	endtask
	// Block read: count byte c, then len bytes from index s
	task automatic br(input logic [7:0] n, input logic [7:0] c, input logic [7:0] s,
			input int len);
		sibt_host_model_inst.start();
		wx(SIBT_WR_ADDR, 1'b0);
		wx(n, 1'b0);
		sibt_host_model_inst.start();
		wx(SIBT_RD_ADDR, 1'b0);
		sibt_host_model_inst.xfer(8'hff, 1'b0, q, q_a);
		chk(q, c);
		for (int k = 0; k < len; k++) begin
			sibt_host_model_inst.xfer(8'hff, k == len - 1, q, q_a);
			chk(q, exp_m[8'(s + k)]);
		end
		sibt_host_model_inst.stop();
		chk(8'(o_busy), 8'h00);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ---
	// Processes
	// ---
	// Clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// Register file stand-in
	always @(posedge i_clock) begin
		if (o_wr.en === 1'b1) mem[o_wr.index] <= o_wr.data;
	end
	// Watchdog, about four times the expected run
	initial begin
		repeat (30000) @(posedge i_clock);
		errors++;
		print_verdict();
	end
	// Main sequence
	initial begin
		errors = 0;
		total_checks = 0;
		clk_en = 1'b1;
		i_reset_n = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
			exp_m[i] = 8'(i) ^ 8'h5a;
		end
		repeat (6) @(negedge i_clock);
		i_reset_n = 1'b1;
		repeat (8) @(negedge i_clock);
		chk({7'h00, o_sda_oe_n}, 8'h01);
		chk(rd_idx, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			bw(rows[i][31:24], rows[i][23:16], rows[i][15:0], 1'b0);
			br(rows[i][31:24], RC, rows[i][31:24], int'(rows[i][23:16]));
			$display("row %0d done", i);
		end
		// Foreign address and surplus byte
		sibt_host_model_inst.start();
		wx(8'ha4, 1'b1);
		sibt_host_model_inst.stop();
		bw(8'h20, 8'h01, 16'h1100, 1'b1);
		// Count held in byte 8
		bw(8'h08, 8'h01, 16'h0300, 1'b0);
		br(8'h05, 8'h03, 8'h00, 4);
		$display("edge tests done");
		// Enable low must freeze the ack that is being driven
		sibt_host_model_inst.start();
		wx(SIBT_WR_ADDR, 1'b0);
		clk_en = 1'b0;
		repeat (10) @(negedge i_clock);
		chk({7'h00, o_sda_oe_n}, 8'h00);
		clk_en = 1'b1;
		wx(8'h40, 1'b0);
		// Reset in mid-transfer frees the line and clears the snooped count
		i_reset_n = 1'b0;
		@(negedge i_clock);
		chk({7'h00, o_sda_oe_n}, 8'h01);
		chk(8'(o_busy), 8'h00);
		repeat (3) @(negedge i_clock);
		i_reset_n = 1'b1;
		repeat (8) @(negedge i_clock);
		sibt_host_model_inst.stop();
		chk(8'(o_busy), 8'h00);
		br(8'h03, RC, 8'h03, 1);
		$display("mid-run reset test done");
		print_verdict();
	end
endmodule
